// ===== dv/bus_transmission_mode_detect_sva.sv
`timescale 1ns/10ps
module mode_detect_sva #(parameter STABLE_CYCLES = 20)
(
    input wire       clk_i, reset_i,
    input wire       above_0v5_i, above_0v7_i, above_1v9_i, above_2v4_i,
    input wire [1:0] mode_o,
    input wire       drivers_hiz_o, term_diff_o, term_se_o,
    input wire       ground_drv_o, mode_change_o
);
    wire [1:0] cls = !above_0v5_i ? 2'h0 : (above_0v7_i && !above_1v9_i)
        ? 2'h1 : above_2v4_i ? 2'h2 : 2'h3;
    reg [1:0] prev;
    int       run, up;
    always @(posedge clk_i)
    begin
        prev <= cls;
        run  <= (cls != prev) ? 0 : run + 1;
        up   <= reset_i ? 0 : up + 1;
    end
    sequence qual_s;
        mode_change_o ##0 mode_o != 2'h3;
    endsequence
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    mode_valid_a: assert property (mode_change_o |-> qual_s)
        else $error("mode change to indeterminate");
    change_hold_a: assert property (qual_s
        |-> run >= STABLE_CYCLES - 1)
        else $error("mode changed before stable time");
    power_wait_a: assert property (mode_change_o
        |-> up >= 2 * STABLE_CYCLES)
        else $error("mode qualified too early");
    change_flag_a: assert property ($changed(mode_o) |-> mode_change_o)
        else $error("mode change without flag");
    hvd_hiz_a: assert property (mode_o == 2'h2 && $past(mode_o) == 2'h2
        |-> drivers_hiz_o)
        else $error("drivers active in hvd");
    drive_ready_a: assert property (!drivers_hiz_o
        |-> $past(mode_o) < 2'h2)
        else $error("drivers active without mode");
    ground_se_a: assert property (
        ground_drv_o == ($past(mode_o) == 2'h0))
        else $error("ground driver mismatch");
    term_diff_a: assert property (term_diff_o
        |-> $past(mode_o) == 2'h1)
        else $error("diff termination off mode");
    term_se_a: assert property (term_se_o |-> $past(mode_o) == 2'h0)
        else $error("se termination off mode");
endmodule // mode_detect_sva
bind bus_transmission_mode_detect mode_detect_sva
    #(.STABLE_CYCLES(STABLE_CYCLES)) u_sva (.clk_i, .reset_i, .above_0v5_i,
    .above_0v7_i, .above_1v9_i, .above_2v4_i, .mode_o, .drivers_hiz_o,
    .term_diff_o, .term_se_o, .ground_drv_o, .mode_change_o);

// ===== dv/sense_line_model.sv
`timescale 1ns/10ps
module sense_line_model
(
    input wire sense_drive_i,
    input int  ext_mv_i,
    output wire above_0v5_o, above_0v7_o, above_1v9_o, above_2v4_o
);
    int mv;
    // Another device's level dominates; a released line falls to ground.
    assign mv = ext_mv_i >= 0 ? ext_mv_i : (sense_drive_i ? 1300 : 0);
    assign above_0v5_o = mv > 500;
    assign above_0v7_o = mv >= 700;
    assign above_1v9_o = mv > 1900;
    assign above_2v4_o = mv >= 2400;
endmodule // sense_line_model

// ===== dv/tb_bus_transmission_mode_detect.sv
`timescale 1ns/10ps
`include "mode_detect_defs.vh"
module tb_bus_transmission_mode_detect;
    localparam int SC = 20;
    logic clk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [11:0] paddr_i = 12'h0;
    logic [31:0] pwdata_i = 32'h0, rd;
    wire pready_o, pslverr_o, sense_drive_o, drivers_hiz_o, term_diff_o;
    wire term_se_o, ground_drv_o, mode_change_o, irq_o, a5, a7, a19, a24;
    wire [31:0] prdata_o;
    wire [1:0] mode_o;
    int ext = -1, seed = 32'h0c53, n_mismatch = 0, num_checks = 0;
    int i, k, c, nchg = 0;
    logic err;
    bus_transmission_mode_detect #(.STABLE_CYCLES(SC)) i_dut (.clk_i,
        .reset_i, .above_0v5_i(a5), .above_0v7_i(a7), .above_1v9_i(a19),
        .above_2v4_i(a24), .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .pready_o, .pslverr_o, .prdata_o, .sense_drive_o, .mode_o,
        .drivers_hiz_o, .term_diff_o, .term_se_o, .ground_drv_o,
        .mode_change_o, .irq_o);
    sense_line_model i_line (.sense_drive_i(sense_drive_o), .ext_mv_i(ext),
        .above_0v5_o(a5), .above_0v7_o(a7), .above_1v9_o(a19),
        .above_2v4_o(a24));
    initial forever #2.5 clk_i = ~clk_i;
    always @(negedge clk_i) if (mode_change_o === 1'b1) nchg++;
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function logic [1:0] cls_of(input int mv);
        if (mv < 0) mv = 1300;
        if (mv <= 500) return 2'h0;
        if (mv >= 700 && mv <= 1900) return 2'h1;
        if (mv >= 2400) return 2'h2;
        return 2'h3;
    endfunction
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
        @(posedge clk_i) penable_i <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge clk_i);
            if (pready_o === 1'b1)
                break;
        end
        if (i == 50) begin n_mismatch++; wrap_up; end
        rd = prdata_o; err = pslverr_o;
        psel_i <= 1'b0; penable_i <= 1'b0;
    endtask
    task settle(input int mv);
        @(posedge clk_i) ext <= mv;
        for (i = 0; i < 400 && mode_change_o !== 1'b1; i++) @(negedge clk_i);
        if (i == 400) begin n_mismatch++; wrap_up; end
        chk(mode_o, cls_of(mv));
        @(negedge clk_i);
    endtask
    initial
    begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        @(negedge clk_i) chk({mode_o, drivers_hiz_o}, 3'h7);
        settle(-1);
        chk({term_diff_o, drivers_hiz_o}, 2'h2);
        c = nchg;
        for (k = 0; k < 6; k++)
        begin
            @(posedge clk_i) ext <= k[0] ? (k[1] ? 2100 : 600)
                : {$random(seed)} % 501;
            repeat (k[0] ? 3 * SC : 1 + {$random(seed)} % (SC - 1))
                @(posedge clk_i);
        end
        @(posedge clk_i) ext <= -1;
        repeat (3 * SC) @(negedge clk_i);
        chk({nchg[29:0], mode_o}, {c[29:0], 2'h1});
        settle({$random(seed)} % 501);
        chk({ground_drv_o, term_se_o, drivers_hiz_o}, 3'h6);
        apb(1'b0, `ADDR_IRQ_STAT, 32'h0);
        chk(rd, 32'h7);
        apb(1'b1, `ADDR_IRQ_MASK, 32'h1);
        @(negedge clk_i) chk(irq_o, 1'b1);
        apb(1'b1, `ADDR_IRQ_STAT, 32'h7);
        @(negedge clk_i) chk(irq_o, 1'b0);
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        settle(2400 + {$random(seed)} % 3101);
        chk({drivers_hiz_o, ground_drv_o}, 2'h2);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        chk(rd, 32'hBA);
        apb(1'b1, `ADDR_CTRL, 32'h0);
        repeat (2) @(negedge clk_i);
        chk(sense_drive_o, 1'b0);
        @(posedge clk_i) reset_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        @(negedge clk_i) chk({mode_o, drivers_hiz_o}, 3'h7);
        settle(-1);
        wrap_up;
    end
endmodule // tb_bus_transmission_mode_detect

// ===== rtl/bus_transmission_mode_detect.v
`timescale 1ns/10ps
// Notes on behaviour
// - Tell single-ended, low-voltage and high-voltage differential apart.
// - Bands: SE to 0.5V, LVD 0.7 to 1.9V, HVD from 2.4V.
// - Gap levels are indeterminate and never a valid new mode.
// - Drivers stay off until logic has run at least 100 ms.
// - Drivers stay off until mode stable a further 100 ms.
// - Change driver or receiver mode only after 100 ms unbroken new mode.
// - Terminator actively sources the LVD level onto the sense line.
// - Terminator keeps monitoring the sense line while driving it.
// - Terminator picks its mode from the same decoded bands.
// - LVD mode gives differential, SE mode single-ended termination.
// - Ground driver on exactly while qualified mode is single-ended.
// - On HVD, all bus signals except the sense line go high impedance.
// - Ground drivers stay on while powered and decoding single-ended; here on only while the qualified mode is single-ended.
`include "mode_detect_defs.vh"

module bus_transmission_mode_detect
#(
    parameter STABLE_CYCLES = `STABLE_CYCLES
)
(
    // Clock and reset.
    input  wire        clk_i,
    input  wire        reset_i,
    // Comparator outputs on the sense line.
    input  wire        above_0v5_i,
    input  wire        above_0v7_i,
    input  wire        above_1v9_i,
    input  wire        above_2v4_i,
    // APB slave.
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output wire        pready_o,
    output wire        pslverr_o,
    output reg  [31:0] prdata_o,
    // Sense line LVD source driver.
    output reg         sense_drive_o,
    // Mode outputs and interrupt.
    output reg  [1:0]  mode_o,
    output reg         drivers_hiz_o,
    output reg         term_diff_o,
    output reg         term_se_o,
    output reg         ground_drv_o,
    output reg         mode_change_o,
    output wire        irq_o
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Maps the four comparator levels to a line class. Anything that falls
    // between two bands reports indeterminate and never qualifies.
    function [1:0] line_class;
        input a0v5;
        input a0v7;
        input a1v9;
        input a2v4;
        begin
            if (!a0v5)
                line_class = `CLS_SE;
            else if (a0v7 && !a1v9)
                line_class = `CLS_LVD;
            else if (a2v4)
                line_class = `CLS_HVD;
            else
                line_class = `CLS_INDET;
        end
    endfunction

    // True when the bus address selects the given register word.
    function addr_hit;
        input [11:0] addr;
        input [11:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    // True when the qualified mode equals the given class.
    function mode_is;
        input [1:0] mode;
        input [1:0] target;
        begin
            mode_is = (mode == target);
        end
    endfunction

    // Steps the stability counter by one; it never runs past the limit
    // because every caller first checks the terminal count.
    function [`CNT_W-1:0] count_up;
        input [`CNT_W-1:0] value;
        begin
            count_up = value + {{(`CNT_W-1){1'b0}}, 1'b1};
        end
    endfunction

    // ------------------------------------------------------------------
    // Line decode
    // ------------------------------------------------------------------
    // The decode is purely combinational; the stability timer below is
    // the only filter against chatter on the line.
    reg [1:0] cls;

    always @*
    begin
        cls = line_class(above_0v5_i, above_0v7_i, above_1v9_i, above_2v4_i);
    end

    // ------------------------------------------------------------------
    // Stability timing
    // ------------------------------------------------------------------
    // One counter serves the power-on interval and every candidate; a
    // 100 ms count is far longer than any comparator chatter.
    // After reset the counter first times the power-on interval; only then
    // is a candidate class taken and timed for a second full interval.
    // Limitation: the counter is CNT_W bits wide, so the stable time in
    // clock cycles must stay below two to the power of that width.
    localparam integer      LIMIT_FULL = STABLE_CYCLES - 1;
    localparam [`CNT_W-1:0] LIMIT      = LIMIT_FULL[`CNT_W-1:0];

    reg [`CNT_W-1:0] cnt_reg;
    reg [1:0]        cand_reg;
    reg              power_ok_reg;
    reg              ready_reg;
    reg              term_en_reg;
    reg [`IRQ_W-1:0] irq_stat_reg;
    reg [`IRQ_W-1:0] irq_mask_reg;

    // A candidate qualifies once it has been sampled unbroken for the
    // whole interval; the first one sets ready_reg and the first mode,
    // every later differing one is a mode change.
    wire cnt_done  = (cnt_reg == LIMIT);
    wire cand_hit  = (cls == cand_reg) && (cls != `CLS_INDET);
    wire new_mode  = ready_reg && cand_hit && cnt_done &&
                     (cand_reg != mode_o);
    wire got_ready = power_ok_reg && !ready_reg && cand_hit && cnt_done;
    wire hit_indet = (cls == `CLS_INDET);

    always @(posedge clk_i)
    begin
        if (reset_i)
        begin
            cnt_reg      <= {`CNT_W{1'b0}};
            cand_reg     <= `CLS_INDET;
            power_ok_reg <= 1'b0;
            ready_reg    <= 1'b0;
            mode_o       <= `CLS_INDET;
            mode_change_o <= 1'b0;
        end
        else
        begin
            mode_change_o <= 1'b0;
            if (!power_ok_reg)
            begin
                if (cnt_done)
                begin
                    power_ok_reg <= 1'b1;
                    cnt_reg      <= {`CNT_W{1'b0}};
                    cand_reg     <= cls;
                end
                else
                begin
                    // Power-on interval still running.
                    cnt_reg <= count_up(cnt_reg);
                end
            end
            else if (!cand_hit)
            begin
                cnt_reg  <= {`CNT_W{1'b0}};
                cand_reg <= cls;
            end
            else if (!cnt_done)
            begin
                // Candidate still being timed.
                cnt_reg <= count_up(cnt_reg);
            end
            else if (!ready_reg)
            begin
                ready_reg <= 1'b1;
                mode_o    <= cand_reg;
                mode_change_o <= 1'b1;
            end
            else if (new_mode)
            begin
                mode_o        <= cand_reg;
                mode_change_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Mode outputs
    // ------------------------------------------------------------------
    // Next values are formed from the qualified mode only, never from the
    // raw decode, so a glitch on the line cannot reach the bus drivers.
    // One view per class of the qualified mode.
    wire in_se  = mode_is(mode_o, `CLS_SE);
    wire in_lvd = mode_is(mode_o, `CLS_LVD);
    wire in_hvd = mode_is(mode_o, `CLS_HVD);

    // A high-voltage bus releases every driver except the line source, whatever else is set.
    wire drivers_hiz_next = !ready_reg || in_hvd;
    wire term_diff_next   = term_en_reg && ready_reg && in_lvd;
    wire term_se_next     = term_en_reg && ready_reg && in_se;
    wire ground_drv_next  = ready_reg && in_se;
    // The level source stays on whatever the decode says, so sensing
    // goes on while the line is driven.
    wire sense_drive_next = term_en_reg;

    always @(posedge clk_i)
    begin
        if (reset_i)
        begin
            // Drivers come up released and the line source off, so a
            // device in reset never disturbs the bus.
            drivers_hiz_o <= 1'b1;
            term_diff_o   <= 1'b0;
            term_se_o     <= 1'b0;
            ground_drv_o  <= 1'b0;
            sense_drive_o <= 1'b0;
        end
        else
        begin
            drivers_hiz_o <= drivers_hiz_next;
            term_diff_o   <= term_diff_next;
            term_se_o     <= term_se_next;
            ground_drv_o  <= ground_drv_next;
            sense_drive_o <= sense_drive_next;
        end
    end

    // ------------------------------------------------------------------
    // APB registers and interrupt
    // ------------------------------------------------------------------
    // The slave never stretches a transfer: every access completes in the
    // cycle after its setup, so pready is simply tied high.
    wire acc_phase = psel_i && penable_i;
    wire wr_acc    = acc_phase && pwrite_i;
    wire rd_setup  = psel_i && !penable_i && !pwrite_i;

    // Decoded register selects.
    wire sel_status = addr_hit(paddr_i, `ADDR_STATUS);
    wire sel_stat   = addr_hit(paddr_i, `ADDR_IRQ_STAT);
    wire sel_mask   = addr_hit(paddr_i, `ADDR_IRQ_MASK);
    wire sel_ctrl   = addr_hit(paddr_i, `ADDR_CTRL);
    wire known      = sel_status || sel_stat || sel_mask || sel_ctrl;

    // Writes take effect at the access edge; writes to unmapped words
    // are simply dropped.
    wire wr_stat = wr_acc && sel_stat;
    wire wr_mask = wr_acc && sel_mask;
    wire wr_ctrl = wr_acc && sel_ctrl;

    // Event bits: bit 0 a later mode change, bit 1 first qualification,
    // bit 2 an indeterminate decode while a mode is held.
    wire [`IRQ_W-1:0] irq_set = {hit_indet && ready_reg, got_ready,
                                 new_mode};
    // Writing a one clears a bit; writing a zero leaves it alone.
    wire [`IRQ_W-1:0] irq_clr = wr_stat ? pwdata_i[`IRQ_W-1:0] :
                                          {`IRQ_W{1'b0}};

    // Status word; the live line class is included so software can see
    // what the timer is presently working on.
    wire [31:0] status_word = {24'h0, drivers_hiz_o, ground_drv_o,
                               power_ok_reg, ready_reg, cls, mode_o};

    assign pready_o  = 1'b1;
    // Unmapped words answer with an error in the access phase.
    assign pslverr_o = acc_phase && !known;
    // Level output, high while any unmasked event bit is set.
    assign irq_o     = |(irq_stat_reg & irq_mask_reg);

    always @(posedge clk_i)
    begin
        if (reset_i)
        begin
            irq_stat_reg <= {`IRQ_W{1'b0}};
            irq_mask_reg <= `MASK_RESET_VAL;
            term_en_reg  <= `CTRL_RESET_VAL;
        end
        else
        begin
            // A new event wins over a clear in the same cycle.
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
            if (wr_mask)
            begin
                irq_mask_reg <= pwdata_i[`IRQ_W-1:0];
            end
            // Clearing the enable also drops the line source, which
            // leaves the line level to the other terminators.
            if (wr_ctrl)
            begin
                term_en_reg <= pwdata_i[`CTRL_TERM_EN];
            end
        end
    end

    // Read data are captured in the setup cycle so that they stand
    // through the whole access phase.
    always @(posedge clk_i)
    begin
        if (reset_i)
            prdata_o <= 32'h0;
        else if (rd_setup)
        begin
            case (paddr_i)
                `ADDR_STATUS:
                begin
                    prdata_o <= status_word;
                end
                `ADDR_IRQ_STAT:
                begin
                    prdata_o <= {29'h0, irq_stat_reg};
                end
                `ADDR_IRQ_MASK:
                begin
                    prdata_o <= {29'h0, irq_mask_reg};
                end
                `ADDR_CTRL:
                begin
                    prdata_o <= {31'h0, term_en_reg};
                end
                default:
                begin
                    // Unmapped words read as zero.
                    prdata_o <= 32'h0;
                end
            endcase
        end
    end

endmodule // bus_transmission_mode_detect

// ===== rtl/mode_detect_defs.vh
`ifndef MODE_DETECT_DEFS_VH
`define MODE_DETECT_DEFS_VH

// Decoded line classes and qualified modes.
`define CLS_SE          2'h0
`define CLS_LVD         2'h1
`define CLS_HVD         2'h2
`define CLS_INDET       2'h3

// Stability time and clock rate.
`define STABLE_TIME_MS  100
`define CLK_HZ          200000000
`define STABLE_CYCLES   (`STABLE_TIME_MS * (`CLK_HZ / 1000))
`define CNT_W           25

// APB register byte addresses.
`define ADDR_STATUS     12'h000
`define ADDR_IRQ_STAT   12'h004
`define ADDR_IRQ_MASK   12'h008
`define ADDR_CTRL       12'h00C

// Interrupt status bits.
`define IRQ_CHANGE      0
`define IRQ_READY       1
`define IRQ_INDET       2
`define IRQ_W           3

// Control bits and reset values.
`define CTRL_TERM_EN    0
`define CTRL_RESET_VAL  1'h1
`define MASK_RESET_VAL  3'h0

`endif
